//--- common/jpo_pkg.sv
// Package of constants and types for the jog pulse output block.
// Functional notes
// - Reverse jog with both limits closed and forward jog off starts reverse pulses.
// - Pulse plus direction mode in reverse: pulse toggles, direction held low.
// - Separate pulse mode in reverse: forward pulse held low, reverse pulse toggles.
// - Reverse motion decreases the 32-bit current position count per pulse.
// - Releasing reverse jog stops toggling; direction or idle pulse stays low.
// - Once stopped, the current position count holds its value.
// - Reverse limit opening during reverse motion stops pulses like a normal stop.
// - A stop caused by a limit input sets the abnormal end flag.
// - Forward jog emits pulses, with direction high in pulse plus direction mode, and increases the position count.
package jpo_pkg;

    // Synchronised input bit positions.
    localparam int IN_W = 4;
    localparam int IN_FWD_LIM = 0;
    localparam int IN_REV_LIM = 1;
    localparam int IN_JOG_FWD = 2;
    localparam int IN_JOG_REV = 3;

    // Register byte offsets.
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_HALF = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_MASK = 5'h0C;
    localparam logic [4:0] OFF_POS = 5'h10;

    // Field positions.
    localparam int CTRL_SEP = 0;
    localparam int EV_W = 3;
    localparam int EV_ABN = 0;
    localparam int EV_START = 1;
    localparam int EV_STOP = 2;
    localparam int STAT_BUSY = 8;
    localparam int STAT_DIR = 9;

    // Reset values.
    localparam logic CTRL_RST = 1'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [31:0] POS_RST = 32'h0000_0000;

    // Timing: default jog rate, expressed as half a pulse period in clocks.
    localparam int CLK_HZ = 25_000_000;
    localparam int JOG_FREQ_HZ = 30_000;
    localparam logic [15:0] HALF_PERIOD_RST =
        16'(CLK_HZ / (2 * JOG_FREQ_HZ));

    typedef enum logic [1:0] {ST_IDLE, ST_FWD, ST_REV} jpo_state_t;

endpackage : jpo_pkg

//--- dv/jpo_drive_model.sv
// Pulse input stage of a motor drive that counts the steps it receives.
`timescale 1ns/10ps
`default_nettype none
module jpo_drive_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sep,
    input wire logic pulse_out,
    input wire logic dir_out,
    input wire logic fwd_pulse_out,
    input wire logic rev_pulse_out,
    output var int n_up,
    output var int n_dn,
    output var int n_bad
);
    logic p_q;
    logic f_q;
    logic r_q;

    // A drive latches a step on the rising pulse edge only, so a level
    // that never falls again is counted once, as real hardware would.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            p_q <= 1'b0;
            f_q <= 1'b0;
            r_q <= 1'b0;
            n_up <= 0;
            n_dn <= 0;
            n_bad <= 0;
        end
        else
        begin
            p_q <= pulse_out;
            f_q <= fwd_pulse_out;
            r_q <= rev_pulse_out;
            if (!sep && pulse_out && !p_q)
            begin
                if (dir_out)
                    n_up <= n_up + 1;
                else
                    n_dn <= n_dn + 1;
            end
            if (sep && fwd_pulse_out && !f_q)
                n_up <= n_up + 1;
            if (sep && rev_pulse_out && !r_q)
                n_dn <= n_dn + 1;
            if (sep && ((pulse_out && !p_q) || dir_out))
                n_bad <= n_bad + 1;
        end
    end
endmodule : jpo_drive_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the jog pulse block and its drive model.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rst, rd_en, wr_en, lim_f, lim_r, jog_f, jog_r, sep;
    logic pulse, dir, fp, rp, abn, irq, waitreq;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, pos, p0;
    logic [31:0] expq[$];
    int n_errors, cmp_count, cyc, d0, u0, n_up, n_dn, n_bad;

    jpo_top u_jpo_top (.clk(clk), .rst(rst), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
        .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .fwd_limit_in(lim_f),
        .rev_limit_in(lim_r), .jog_fwd_in(jog_f), .jog_rev_in(jog_r),
        .pulse_out(pulse), .dir_out(dir), .fwd_pulse_out(fp),
        .rev_pulse_out(rp), .abnormal_end_flag(abn),
        .current_position_count(pos), .irq(irq));

    jpo_drive_model u_jpo_drive_model (.clk(clk), .rst(rst), .sep(sep),
        .pulse_out(pulse), .dir_out(dir), .fwd_pulse_out(fp),
        .rev_pulse_out(rp), .n_up(n_up), .n_dn(n_dn), .n_bad(n_bad));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Read data is judged by the watcher below at the answering edge.
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic jog(input logic fwd, input int n);
        if (fwd)
            jog_f <= 1'b1;
        else
            jog_r <= 1'b1;
        repeat (n) @(posedge clk);
        jog_f <= 1'b0;
        jog_r <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : jog

    task automatic motion(input logic fwd, input logic m);
        d0 = n_dn;
        u0 = n_up;
        jog(fwd, 40 + int'($urandom % 40));
        chk(32'(fwd ? n_dn - d0 : n_up - u0), 0);
        chk(32'((fwd ? n_up - u0 : n_dn - d0) > 0), 1);
        chk(pos, 32'(n_up - n_dn));
        chk({pulse, fp, rp, dir}, {3'b000, fwd & ~m});
        p0 = pos;
        repeat (20) @(posedge clk);
        chk(pos, p0);
    endtask : motion

    always @(posedge clk)
        if (rd_en && waitreq === 1'b0)
            chk(rdata, expq.pop_front());

    // The ceiling leaves roughly fifty times the expected run length.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        rst = 1'b1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 5'h00;
        wdata = 32'h0000_0000;
        lim_f = 1'b1;
        lim_r = 1'b1;
        jog_f = 1'b0;
        jog_r = 1'b0;
        sep = 1'b0;
        void'($urandom(32'h9a59_0186));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({pulse, dir, fp, rp, abn, irq, waitreq}, 32'h0000_0001);
        chk(pos, 32'h0000_0000);
        rd(jpo_pkg::OFF_HALF, 32'(jpo_pkg::HALF_PERIOD_RST));
        rd(5'h14, 32'h0000_0000);
        rd(jpo_pkg::OFF_CTRL, 32'h0000_0000);
        wr(jpo_pkg::OFF_HALF, 32'(1 + $urandom % 3));
        wr(jpo_pkg::OFF_MASK, 32'h0000_0001);
        repeat (5) @(posedge clk);
        jog_f <= 1'b1;
        jog_r <= 1'b1;
        repeat (40) @(posedge clk);
        jog_f <= 1'b0;
        jog_r <= 1'b0;
        repeat (6) @(posedge clk);
        chk(32'(n_up + n_dn), 32'h0000_0000);
        for (int m = 0; m < 2; m++)
        begin
            sep <= m[0];
            wr(jpo_pkg::OFF_CTRL, 32'(m));
            // The output mode is latched only when a move starts. Ending
            // each mode on a reverse move leaves the direction low, so it
            // is not seen as high in separate mode before the next start.
            motion(1'b1, m[0]);
            motion(1'b0, m[0]);
        end
        chk(32'(n_bad), 32'h0000_0000);
        sep <= 1'b0;
        wr(jpo_pkg::OFF_CTRL, 32'h0000_0000);
        wr(jpo_pkg::OFF_STATUS, 32'h0000_0007);
        rd(jpo_pkg::OFF_POS, 32'(n_up - n_dn));
        jog_r <= 1'b1;
        repeat (30) @(posedge clk);
        lim_r <= 1'b0;
        repeat (6) @(posedge clk);
        d0 = n_dn;
        p0 = pos;
        repeat (20) @(posedge clk);
        chk(32'(n_dn - d0), 32'h0000_0000);
        chk(pos, p0);
        chk({pulse, dir, abn, irq}, 32'h0000_0003);
        rd(jpo_pkg::OFF_STATUS, 32'h0000_0007);
        wr(jpo_pkg::OFF_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0000_0000);
        wr(jpo_pkg::OFF_MASK, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0000_0001);
        jog_r <= 1'b0;
        lim_r <= 1'b1;
        repeat (6) @(posedge clk);
        wr(jpo_pkg::OFF_STATUS, 32'h0000_0007);
        repeat (3) @(posedge clk);
        chk({abn, irq}, 32'h0000_0000);
        final_report();
    end
endmodule : tb
`default_nettype wire

//--- hw/jpo_sync.sv
// Three-stage input synchroniser with agreement filter for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module jpo_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [jpo_pkg::IN_W-1:0] pin,
    output logic [jpo_pkg::IN_W-1:0] level
);

    logic [jpo_pkg::IN_W-1:0] s1;
    logic [jpo_pkg::IN_W-1:0] s2;
    logic [jpo_pkg::IN_W-1:0] s3;

    genvar i;
    generate
        for (i = 0; i < jpo_pkg::IN_W; i++)
        begin : g_bit
            // The filtered level moves only when stages two and three agree.
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    s1[i] <= 1'h0;
                    s2[i] <= 1'h0;
                    s3[i] <= 1'h0;
                    level[i] <= 1'h0;
                end
                else
                begin
                    s1[i] <= pin[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i])
                    begin
                        level[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate

endmodule : jpo_sync
`default_nettype wire

//--- hw/jpo_top.sv
// Jog pulse generator with position count, limit stop and register slave.
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module jpo_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fwd_limit_in,
    input wire logic rev_limit_in,
    input wire logic jog_fwd_in,
    input wire logic jog_rev_in,
    output logic pulse_out,
    output logic dir_out,
    output logic fwd_pulse_out,
    output logic rev_pulse_out,
    output logic abnormal_end_flag,
    output logic [31:0] current_position_count,
    output logic irq
);

    typedef struct packed {
        jpo_pkg::jpo_state_t state;
        logic ctrl_sep;
        logic sep;
        logic dir;
        logic phase;
        logic [15:0] half_period;
        logic [15:0] cnt;
        logic [31:0] position;
        logic [2:0] status;
        logic [2:0] mask;
        logic waitrequest;
        logic [31:0] readdata;
        logic pulse_out;
        logic dir_out;
        logic fwd_pulse_out;
        logic rev_pulse_out;
        logic irq;
    } jpo_regs_t;

    jpo_regs_t s;
    jpo_regs_t next_s;
    logic [jpo_pkg::IN_W-1:0] in_lvl;
    logic fwd_lim;
    logic rev_lim;
    logic jog_fwd;
    logic jog_rev;
    logic wr_en;
    logic [2:0] ev_set;
    logic [15:0] hp_last;
    logic running;
    logic [31:0] rd_mux;

    jpo_sync u_sync
    (
        .clk(clk),
        .rst(rst),
        .pin({jog_rev_in, jog_fwd_in, rev_limit_in, fwd_limit_in}),
        .level(in_lvl)
    );

    // Limits read high while the normally closed contact is intact.
    assign fwd_lim = in_lvl[jpo_pkg::IN_FWD_LIM];
    assign rev_lim = in_lvl[jpo_pkg::IN_REV_LIM];
    assign jog_fwd = in_lvl[jpo_pkg::IN_JOG_FWD];
    assign jog_rev = in_lvl[jpo_pkg::IN_JOG_REV];

    always_comb
    begin
        next_s = s;
        ev_set = 3'h0;
        wr_en = avs_write && !s.waitrequest;
        rd_mux = 32'h0000_0000;
        running = 1'h0;
        hp_last = (s.half_period == 16'h0000) ? 16'h0000
                                              : s.half_period - 16'h0001;

        case (avs_address)
            jpo_pkg::OFF_CTRL: rd_mux[jpo_pkg::CTRL_SEP] = s.ctrl_sep;
            jpo_pkg::OFF_HALF: rd_mux[15:0] = s.half_period;
            jpo_pkg::OFF_STATUS:
            begin
                rd_mux[2:0] = s.status;
                rd_mux[jpo_pkg::STAT_BUSY] = (s.state != jpo_pkg::ST_IDLE);
                rd_mux[jpo_pkg::STAT_DIR] = s.dir;
            end
            jpo_pkg::OFF_MASK: rd_mux[2:0] = s.mask;
            jpo_pkg::OFF_POS: rd_mux = s.position;
            default: rd_mux = 32'h0000_0000;
        endcase

        // One wait cycle, then the answer stands for one edge.
        if ((avs_read || avs_write) && s.waitrequest)
        begin
            next_s.waitrequest = 1'h0;
            next_s.readdata = rd_mux;
        end
        else
        begin
            next_s.waitrequest = 1'h1;
        end

        if (wr_en)
        begin
            case (avs_address)
                jpo_pkg::OFF_CTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.ctrl_sep = avs_writedata[jpo_pkg::CTRL_SEP];
                    end
                end
                jpo_pkg::OFF_HALF:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.half_period[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1])
                    begin
                        next_s.half_period[15:8] = avs_writedata[15:8];
                    end
                end
                jpo_pkg::OFF_STATUS:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.status = s.status & ~avs_writedata[2:0];
                    end
                end
                jpo_pkg::OFF_MASK:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.mask = avs_writedata[2:0];
                    end
                end
                default: next_s.mask = next_s.mask;
            endcase
        end

        case (s.state)
            jpo_pkg::ST_IDLE:
            begin
                // Opposite jogs together start nothing.
                if (jog_fwd && !jog_rev && fwd_lim && rev_lim)
                begin
                    next_s.state = jpo_pkg::ST_FWD;
                    next_s.dir = 1'h1;
                end
                else if (jog_rev && !jog_fwd && fwd_lim && rev_lim)
                begin
                    next_s.state = jpo_pkg::ST_REV;
                    next_s.dir = 1'h0;
                end
                if (next_s.state != jpo_pkg::ST_IDLE)
                begin
                    // The output mode is frozen for the whole move.
                    next_s.sep = s.ctrl_sep;
                    next_s.cnt = 16'h0000;
                    next_s.phase = 1'h0;
                    ev_set[jpo_pkg::EV_START] = 1'h1;
                end
            end
            jpo_pkg::ST_FWD, jpo_pkg::ST_REV:
            begin
                if ((s.state == jpo_pkg::ST_FWD && !fwd_lim)
                    || (s.state == jpo_pkg::ST_REV && !rev_lim))
                begin
                    next_s.state = jpo_pkg::ST_IDLE;
                    next_s.phase = 1'h0;
                    ev_set[jpo_pkg::EV_ABN] = 1'h1;
                    ev_set[jpo_pkg::EV_STOP] = 1'h1;
                end
                else if ((s.state == jpo_pkg::ST_FWD && (!jog_fwd || jog_rev))
                    || (s.state == jpo_pkg::ST_REV
                        && (!jog_rev || jog_fwd)))
                begin
                    next_s.state = jpo_pkg::ST_IDLE;
                    next_s.phase = 1'h0;
                    ev_set[jpo_pkg::EV_STOP] = 1'h1;
                end
                else if (s.cnt >= hp_last)
                begin
                    next_s.cnt = 16'h0000;
                    next_s.phase = !s.phase;
                    // Count on the rising half so each pulse counts once.
                    if (!s.phase)
                    begin
                        if (s.state == jpo_pkg::ST_FWD)
                        begin
                            next_s.position = s.position + 32'h0000_0001;
                        end
                        else
                        begin
                            next_s.position = s.position - 32'h0000_0001;
                        end
                    end
                end
                else
                begin
                    next_s.cnt = s.cnt + 16'h0001;
                end
            end
            default: next_s.state = jpo_pkg::ST_IDLE;
        endcase

        // A new event outranks a clear written in the same cycle.
        next_s.status = next_s.status | ev_set;

        running = (next_s.state != jpo_pkg::ST_IDLE);
        next_s.pulse_out = running && !next_s.sep && next_s.phase;
        next_s.fwd_pulse_out = running && next_s.sep && next_s.phase
            && (next_s.state == jpo_pkg::ST_FWD);
        next_s.rev_pulse_out = running && next_s.sep && next_s.phase
            && (next_s.state == jpo_pkg::ST_REV);
        next_s.dir_out = !next_s.sep && next_s.dir;
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.state <= jpo_pkg::ST_IDLE;
            s.ctrl_sep <= jpo_pkg::CTRL_RST;
            s.half_period <= jpo_pkg::HALF_PERIOD_RST;
            s.position <= jpo_pkg::POS_RST;
            s.mask <= jpo_pkg::MASK_RST;
            s.waitrequest <= 1'h1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign pulse_out = s.pulse_out;
    assign dir_out = s.dir_out;
    assign fwd_pulse_out = s.fwd_pulse_out;
    assign rev_pulse_out = s.rev_pulse_out;
    assign abnormal_end_flag = s.status[jpo_pkg::EV_ABN];
    assign current_position_count = s.position;
    assign irq = s.irq;

    property p_rev_start;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_IDLE) && jog_rev && !jog_fwd && fwd_lim
            && rev_lim |=> (s.state == jpo_pkg::ST_REV) && !s.dir;
    endproperty
    a_rev_start: assert property (p_rev_start)
        else $error("reverse jog did not start reverse motion");

    property p_rev_dir_low;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_REV) |-> !dir_out;
    endproperty
    a_rev_dir_low: assert property (p_rev_dir_low)
        else $error("direction high during reverse motion");

    property p_sep_rev;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_REV) && s.sep
            |-> !fwd_pulse_out && !pulse_out;
    endproperty
    a_sep_rev: assert property (p_sep_rev)
        else $error("forward pulse active in separate reverse move");

    property p_rev_dec;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_REV) && $rose(pulse_out || rev_pulse_out)
            |-> current_position_count
                == $past(current_position_count) - 32'h0000_0001;
    endproperty
    a_rev_dec: assert property (p_rev_dec)
        else $error("reverse pulse did not decrement position");

    property p_rev_release;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_REV) && !jog_rev
            |=> (s.state == jpo_pkg::ST_IDLE) && !pulse_out
                && !rev_pulse_out && !dir_out;
    endproperty
    a_rev_release: assert property (p_rev_release)
        else $error("reverse jog release did not stop pulses");

    property p_idle_hold;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_IDLE) |=> $stable(current_position_count);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("position changed while stopped");

    property p_limit_stop;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_REV) && !rev_lim
            |=> (s.state == jpo_pkg::ST_IDLE) ##1
                (s.state == jpo_pkg::ST_IDLE) && !rev_pulse_out;
    endproperty
    a_limit_stop: assert property (p_limit_stop)
        else $error("reverse limit did not stop motion");

    property p_limit_flag;
        @(posedge clk) disable iff (rst)
        ((s.state == jpo_pkg::ST_FWD) && !fwd_lim)
            || ((s.state == jpo_pkg::ST_REV) && !rev_lim)
            |=> abnormal_end_flag;
    endproperty
    a_limit_flag: assert property (p_limit_flag)
        else $error("limit stop did not set abnormal end flag");

    property p_fwd_inc;
        @(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_FWD) && $rose(pulse_out || fwd_pulse_out)
            |-> current_position_count
                == $past(current_position_count) + 32'h0000_0001
                && (s.sep || dir_out);
    endproperty
    a_fwd_inc: assert property (p_fwd_inc)
        else $error("forward pulse did not increment position");

    property p_step_one;
        @(posedge clk) disable iff (rst)
        $changed(current_position_count)
            |-> (current_position_count - $past(current_position_count)
                    == 32'h0000_0001)
                || ($past(current_position_count) - current_position_count
                    == 32'h0000_0001);
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("position moved by more than one count");

    c_rev_move: cover property (@(posedge clk) disable iff (rst)
        $rose(rev_pulse_out));
    c_rev_limit: cover property (@(posedge clk) disable iff (rst)
        $rose(abnormal_end_flag));
    c_fwd_move: cover property (@(posedge clk) disable iff (rst)
        (s.state == jpo_pkg::ST_FWD) && $rose(pulse_out));

endmodule : jpo_top
`default_nettype wire
